// *** common/rcc_defs.vh ***
`ifndef RCC_DEFS_VH
`define RCC_DEFS_VH
// register offset (byte address on apb)
`define RCC_REG_ADDR      12'h000
// interrupt mask register offset (byte address on apb)
`define RCC_MASK_ADDR     12'h004
// field positions
`define RCC_BIT_TRAP      15
`define RCC_BIT_ILLEGAL   14
`define RCC_BIT_BOREN     13
`define RCC_BIT_DEEP_SLEEP_FLAG     10
`define RCC_BIT_PMPWR     8
`define RCC_BIT_EXTPIN    7
`define RCC_BIT_SWRST     6
`define RCC_BIT_WDTEN     5
`define RCC_BIT_WATCHDOG_TIMEOUT_FLAG      4
`define RCC_BIT_SLEEP     3
`define RCC_BIT_IDLE      2
// writable / implemented masks
`define RCC_IMPL_MASK     16'hE5FC
`define RCC_FLAG_MASK     16'hC4DC
`define RCC_CTRL_MASK     16'h2120
// reset value of control bits (flags survive)
`define RCC_CTRL_RESET    16'h0000
// reset value of the interrupt mask
`define RCC_MASK_RESET    16'h0000
`endif

// *** hw/rcc_top.v ***
`timescale 1ns/1ps
`include "rcc_defs.vh"
// one 16-bit reset-cause and control register plus an interrupt mask,
// both reached over apb; no wait states on any transfer.
// cause flags sit outside the reset domain so that they can report the
// reset that just happened; they clear only by software writing ones.
// limitation: a cause input held high keeps its flag set, so software
// must wait for the source to drop before a clear sticks.
// the controls drive the brown-out detector, the watchdog timer and the
// program memory bias switch; the blocks they control live elsewhere.
// only byte lanes 0 and 1 matter; the upper half reads zero and is
// ignored on writes.
module rcc_top
(
   // clock and reset
   input  wire        sys_clk,
   input  wire        reset,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // hardware event pulses
   input  wire        ev_trap_conflict,
   input  wire        ev_illegal_access,
   input  wire        ev_deep_sleep,
   input  wire        ev_master_clear_pin,
   input  wire        ev_software_reset,
   input  wire        ev_watchdog_timeout,
   input  wire        ev_sleep_wake,
   input  wire        ev_idle_wake,
   // controls out
   output reg         brownout_detector_en,
   output reg         watchdog_timer_en,
   output reg         sleep_progmem_power,
   // interrupt
   output reg         irq
);
   // cause flags; the declaration value stands in for a power-up clear
   reg  [15:0] flags = 16'h0000;  // sticky cause bits, never touched by reset
   // software side state, cleared by reset
   reg  [15:0] ctrl;              // brown-out, progmem power and watchdog controls
   reg  [15:0] mask;              // interrupt mask, same layout as the flags

   // bus phase states, one-hot
   localparam [1:0] ST_IDLE   = 2'b01;  // no transfer, or a setup cycle
   localparam [1:0] ST_ACCESS = 2'b10;  // access cycle, answer standing
   reg  [1:0]  phase;             // current bus phase
   reg  [1:0]  next_phase;        // phase after this edge

   // bus decode
   wire        setup_ph;          // first cycle of a transfer
   wire        access_done;       // access edge with the answer standing
   reg         hit_reg;           // main register selected
   reg         hit_mask;          // mask register selected
   wire        hit_any;           // either register selected
   wire        wr_reg;            // completed write to the main register
   wire        wr_mask;           // completed write to the mask register
   wire        rd_setup;          // read setup aimed at a mapped register

   // data paths
   wire [15:0] wmask;             // bits enabled by the byte strobes
   wire [15:0] wdata;             // low half of the write word
   wire [15:0] events;            // event inputs placed at their flag positions
   wire [15:0] wr_clear;          // flags that software clears this cycle
   wire [15:0] next_flags;        // flags after events and clears
   wire [15:0] next_ctrl;         // controls after a write
   wire [15:0] next_mask;         // mask after a write
   reg  [15:0] rd_word;           // read mux output
   wire        next_irq;          // interrupt level for the next cycle

   // setup cycle: psel without penable; the answer comes one cycle later
   assign setup_ph    = psel & ~penable;
   // a transfer completes where psel, penable and the access phase meet
   assign access_done = psel & penable & (phase == ST_ACCESS);

   // bus phase; every setup leads to exactly one access cycle, and back
   // to back transfers simply show a new setup right after the access
   always @*
   begin
      next_phase = ST_IDLE;
      case (phase)
         ST_IDLE:
         begin
            if (setup_ph)
            begin
               next_phase = ST_ACCESS;
            end
         end
         ST_ACCESS:
         begin
            // penable is high here, so this only catches a broken master
            if (setup_ph)
            begin
               next_phase = ST_ACCESS;
            end
         end
         default:
         begin
            next_phase = ST_IDLE;
         end
      endcase
   end

   // phase register
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         phase <= ST_IDLE;
      end
      else
      begin
         phase <= next_phase;
      end
   end

   // address decode as a priority chain, main register first
   always @*
   begin
      hit_reg  = 1'b0;
      hit_mask = 1'b0;
      if (paddr == `RCC_REG_ADDR)
      begin
         hit_reg = 1'b1;
      end
      else if (paddr == `RCC_MASK_ADDR)
      begin
         hit_mask = 1'b1;
      end
   end

   // an unmapped address answers with an error and changes nothing
   assign hit_any  = hit_reg | hit_mask;
   // writes take effect at the access edge only
   assign wr_reg   = access_done & pwrite & hit_reg;
   assign wr_mask  = access_done & pwrite & hit_mask;
   // reads sample the register in the setup cycle, one edge before the answer
   assign rd_setup = setup_ph & ~pwrite & hit_any;

   // byte lanes; only the low two lanes reach the 16-bit register
   assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   // the upper half of pwdata has no home and is dropped on purpose
   assign wdata = pwdata[15:0];

   // event inputs, each on its own flag position; a source held high
   // keeps its flag set, so a clear only sticks once the source drops
   // trap conflict
   assign events = ({16{ev_trap_conflict}}    & (16'h0001 << `RCC_BIT_TRAP))
   // illegal opcode, addressing mode or pointer
                 | ({16{ev_illegal_access}}   & (16'h0001 << `RCC_BIT_ILLEGAL))
   // deep sleep
                 | ({16{ev_deep_sleep}}       & (16'h0001 << `RCC_BIT_DEEP_SLEEP_FLAG))
   // master clear pin
                 | ({16{ev_master_clear_pin}} & (16'h0001 << `RCC_BIT_EXTPIN))
   // reset instruction
                 | ({16{ev_software_reset}}   & (16'h0001 << `RCC_BIT_SWRST))
   // watchdog time-out
                 | ({16{ev_watchdog_timeout}} & (16'h0001 << `RCC_BIT_WATCHDOG_TIMEOUT_FLAG))
   // wake from sleep
                 | ({16{ev_sleep_wake}}       & (16'h0001 << `RCC_BIT_SLEEP))
   // wake from idle
                 | ({16{ev_idle_wake}}        & (16'h0001 << `RCC_BIT_IDLE));

   // per-bit register logic; flags, mask and controls share one layout
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1)
      begin : g_bit
         // a flag lives here: write one clears, an event in the same cycle
         // wins so that no cause is lost to a racing clear
         if (((`RCC_FLAG_MASK >> gi) & 1) != 0)
         begin : g_flag
            assign wr_clear[gi]   = wr_reg & wmask[gi] & wdata[gi];
            assign next_flags[gi] = (flags[gi] & ~wr_clear[gi]) | events[gi];
            // mask bits exist only beside a flag
            assign next_mask[gi]  = (wr_mask & wmask[gi]) ? wdata[gi] : mask[gi];
         end
         else
         begin : g_noflag
            // no flag: nothing to clear, reads back zero, writes ignored
            assign wr_clear[gi]   = 1'b0;
            assign next_flags[gi] = 1'b0;
            assign next_mask[gi]  = 1'b0;
         end
         // a software control lives here: plain read and write
         if (((`RCC_CTRL_MASK >> gi) & 1) != 0)
         begin : g_ctrl
            assign next_ctrl[gi] = (wr_reg & wmask[gi]) ? wdata[gi] : ctrl[gi];
         end
         else
         begin : g_noctrl
            assign next_ctrl[gi] = 1'b0;
         end
      end
   endgenerate

   // read mux; flags and controls never overlap, so an or merges them
   always @*
   begin
      rd_word = 16'h0000;
      if (hit_reg)
      begin
         rd_word = flags | ctrl;
      end
      else if (hit_mask)
      begin
         rd_word = mask;
      end
   end

   // interrupt level as it will stand after this edge, so irq tracks
   // the flags and the mask in the same cycle instead of one behind
   assign next_irq = |(next_flags & next_mask);

   // flag register; no reset on purpose: the reset that a flag records
   // must not wipe it, and events are still taken while reset is held
   always @(posedge sys_clk)
   begin
      flags <= next_flags;
   end

   // control and mask registers; reset returns every control to off
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         ctrl <= `RCC_CTRL_RESET;
         mask <= `RCC_MASK_RESET;
      end
      else
      begin
         ctrl <= next_ctrl;
         mask <= next_mask;
      end
   end

   // ready stands for the access cycle only; fixed zero wait states
   // keep the master's side simple
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         pready <= 1'b0;
      end
      else
      begin
         pready <= (next_phase == ST_ACCESS);
      end
   end

   // unmapped address: error with the same timing as ready
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         pslverr <= 1'b0;
      end
      else
      begin
         pslverr <= setup_ph & ~hit_any;
      end
   end

   // read data is taken in the setup cycle and holds until the next
   // setup; writes and unmapped reads answer zero
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         prdata <= 32'h00000000;
      end
      else if (rd_setup)
      begin
         prdata <= {16'h0000, rd_word};
      end
      else if (setup_ph)
      begin
         prdata <= 32'h00000000;
      end
   end

   // brown-out detector switch follows its control bit; taken from the
   // next value so it moves on the same edge as the register
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         brownout_detector_en <= 1'b0;
      end
      else
      begin
         brownout_detector_en <= next_ctrl[`RCC_BIT_BOREN];
      end
   end

   // watchdog timer enable; off after reset until software turns it on
   // again, since the controls do not survive reset as the flags do
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         watchdog_timer_en <= 1'b0;
      end
      else
      begin
         watchdog_timer_en <= next_ctrl[`RCC_BIT_WDTEN];
      end
   end

   // program memory bias during sleep: high keeps it powered, trading
   // sleep current for a faster wake
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         sleep_progmem_power <= 1'b0;
      end
      else
      begin
         sleep_progmem_power <= next_ctrl[`RCC_BIT_PMPWR];
      end
   end

   // level interrupt, high while any unmasked flag is set; quiet after
   // reset because the mask clears even though the flags stay
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= next_irq;
      end
   end
endmodule

// *** verif/rcc_checker.sv ***
`timescale 1ns/1ps
module rcc_checker
(
   // watched ports
   input wire        sys_clk, reset, psel, penable, pwrite, pready,
   input wire [11:0] paddr,
   input wire [31:0] pwdata, prdata,
   input wire        ev_trap_conflict, ev_illegal_access, ev_master_clear_pin,
   input wire        brownout_detector_en, watchdog_timer_en, sleep_progmem_power
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // completed accesses to the main register
   sequence s_wr; psel && penable && pready && pwrite && paddr == 12'h000; endsequence
   sequence s_rd; psel && penable && pready && !pwrite && paddr == 12'h000; endsequence
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_bor; s_wr |=> brownout_detector_en == $past(pwdata[13]); endproperty
   a_bor: assert property (p_bor) else $error("brownout enable wrong");
   property p_pm; s_wr |=> sleep_progmem_power == $past(pwdata[8]); endproperty
   a_pm: assert property (p_pm) else $error("progmem power wrong");
   property p_wdt; s_wr |=> watchdog_timer_en == $past(pwdata[5]); endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog enable wrong");
   property p_unimpl; s_rd |-> (prdata & ~32'h0000E5FC) == 32'h0; endproperty
   a_unimpl: assert property (p_unimpl) else $error("unused bit set");
   property p_trap; ev_trap_conflict ##3 s_rd |-> prdata[15]; endproperty
   a_trap: assert property (p_trap) else $error("trap flag missing");
   property p_ill; ev_illegal_access ##3 s_rd |-> prdata[14]; endproperty
   a_ill: assert property (p_ill) else $error("illegal flag missing");
   property p_ext; ev_master_clear_pin ##3 s_rd |-> prdata[7]; endproperty
   a_ext: assert property (p_ext) else $error("pin flag missing");
endmodule
bind rcc_top rcc_checker u_chk (.*);

// *** verif/tb.sv ***
`timescale 1ns/1ps
`define CHK(a,e) begin n_tests++; if ((a) !== (e)) begin fails++; $display("mismatch %0t %h %h", $time, a, e); end end
module tb;
   logic        sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, er;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [7:0]  ev = 8'h0;
   logic        pready, pslverr, brownout_detector_en, watchdog_timer_en, sleep_progmem_power, irq;
   int          fails = 0, n_tests = 0, pos[8] = '{15, 14, 10, 7, 6, 4, 3, 2};
   rcc_top uut (.*, .pstrb(4'hF), .ev_trap_conflict(ev[0]), .ev_illegal_access(ev[1]),
      .ev_deep_sleep(ev[2]), .ev_master_clear_pin(ev[3]), .ev_software_reset(ev[4]),
      .ev_watchdog_timeout(ev[5]), .ev_sleep_wake(ev[6]), .ev_idle_wake(ev[7]));
   always #10 sys_clk = ~sys_clk;
   // one apb transfer; idle edge first so psel is never set twice in a step
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      {er, rd} = {pslverr, prdata};
      {psel, penable} <= 2'b00;
   endtask
   // one-cycle event pulse
   task pulse(input int i);
      @(posedge sys_clk) ev[i] <= 1;
      @(posedge sys_clk) ev[i] <= 0;
   endtask
   task wrap_up;
      if (fails == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // hang guard, far beyond the 170 or so cycles needed
   initial
   begin
      #200000;
      fails++;
      wrap_up;
   end
   initial
   begin
      repeat (10) @(posedge sys_clk);
      reset <= 0;
      xfer(0, 0, 0); `CHK(rd, 32'h0)
      xfer(1, 0, 32'hFFFFFFFF); xfer(0, 0, 0); `CHK(rd, 32'h2120)
      `CHK({brownout_detector_en, watchdog_timer_en, sleep_progmem_power}, 3'h7)
      xfer(1, 0, 0); xfer(0, 0, 0); `CHK(rd, 32'h0)
      `CHK({brownout_detector_en, watchdog_timer_en, sleep_progmem_power}, 3'h0)
      // every event sets its own sticky flag, cleared by writing one
      for (int i = 0; i < 8; i++)
      begin
         pulse(i);
         xfer(0, 0, 0); `CHK(rd, 32'h1 << pos[i])
         xfer(0, 0, 0); `CHK(rd, 32'h1 << pos[i])
         xfer(1, 0, 32'h1 << pos[i]); xfer(0, 0, 0); `CHK(rd, 32'h0)
      end
      // interrupt: masked event stays quiet, unmasked raises, clear drops
      xfer(1, 12'h004, 32'h8000);
      xfer(0, 12'h004, 0); `CHK(rd, 32'h8000)
      pulse(6); repeat (3) @(negedge sys_clk); `CHK(irq, 1'b0)
      pulse(0); repeat (3) @(negedge sys_clk); `CHK(irq, 1'b1)
      xfer(1, 0, 32'hC4DC); repeat (3) @(negedge sys_clk); `CHK(irq, 1'b0)
      // flag survives the reset it records
      pulse(5);
      @(posedge sys_clk) reset <= 1;
      repeat (2) @(posedge sys_clk);
      reset <= 0;
      xfer(0, 0, 0); `CHK(rd, 32'h10)
      xfer(0, 12'h008, 0); `CHK({er, rd}, 33'h100000000)
      wrap_up;
   end
endmodule
